// ==== hw/adc_ctrl_cfg.svh ====
// Overview of operation
// - A set reference fault enable turns a rising reference fault flag into an interrupt when mask bit 0 is set.
// - A set end-of-scan enable turns a rising end-of-scan ready flag into an interrupt when mask bit 1 is set.
// - Override at one gates early interrupts by the early enables, at zero by the global enables.
// - Lead select n fires the data-ready interrupt n shared-core clocks before conversion end.
// - Divider value n gives a shared core clock period of 2n control clocks; zero is reserved.
// - Cores 0 and 1 take already synchronised triggers when their presync control is set.
// - Cores 0 to 4 sample synchronously on the first sample after idle when enabled.
// - Bits 11 and 7 of control two and bits 7 to 5 of trigger mode read as zero.
// - Each input's early ready flag is set on its early event and interrupts if enabled.
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH
`define ADR_CTRL2       4'h0
`define ADR_TRGMODE     4'h1
`define ADR_EIEN        4'h2
`define ADR_GIEN        4'h3
`define ADR_STATUS      4'h4
`define ADR_MASK        4'h5
`define ADR_EARLY_RDY   4'h6
`define CTRL2_MASK      32'h0000_777f
`define TRGMODE_MASK    32'h0000_031f
`define CTRL2_RESET     32'h0000_0001
`define BIT_REFIEN      14
`define BIT_EOS_EN      13
`define BIT_EIOVR       12
`define NUM_CORES       5
`define NUM_INPUTS      8
`endif

// ==== hw/adc_ctrl_pkg.sv ====
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b01,
    CONV_RUN  = 2'b10
  } conv_state_type;
endpackage

// ==== hw/adc_ctrl.sv ====
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_cfg.svh"
module adc_ctrl #(
  parameter int CONV_CLOCKS = 14
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ref_fault_flag,
  input  wire logic        end_of_scan_ready_flag,
  input  wire logic        convStart,
  input  wire logic [7:0]  earlyEvent,
  input  wire logic [4:0]  triggerIn,
  input  wire logic [4:0]  coreIdle,
  output logic             shared_core_clock,
  output logic             sharedCoreTick,
  output logic             dataReadyIrq,
  output logic             earlyIrq,
  output logic [4:0]       coreTrigger,
  output logic [4:0]       syncSampleNow,
  output logic             irq
);
  logic [31:0] ctrl2_r, ctrl2_nxt, trg_r, trg_nxt;
  logic [7:0]  eien_r, eien_nxt, gien_r, gien_nxt;
  logic [7:0]  earlyRdy_r, earlyRdy_nxt;
  logic [1:0]  stat_r, stat_nxt, mask_r, mask_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [6:0]  divCnt_r, divCnt_nxt, divLast_r;
  logic        sclk_r, sclk_nxt;
  logic [4:0]  convCnt_r, convCnt_nxt;
  logic        dri_r, dri_nxt;
  adc_ctrl_pkg::conv_state_type cst_r, cst_nxt;
  logic [4:0]  s1_r, s2_r, s3_r, trigD_r, idleD_r;
  logic [4:0]  trg_o_nxt, ss_nxt;
  logic        rfD_r, eosD_r;
  logic        wrAcc, rdAcc;
  logic [6:0]  divVal;
  logic [7:0]  gate;
  logic [4:0]  agreed;

  assign wrAcc = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
  assign rdAcc = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_r;
  assign divVal = ctrl2_r[6:0];

  // Register bank and bus slave
  always_comb begin
    ctrl2_nxt = ctrl2_r;
    trg_nxt   = trg_r;
    eien_nxt  = eien_r;
    gien_nxt  = gien_r;
    mask_nxt  = mask_r;
    ack_nxt   = wb_cyc_i & wb_stb_i & ~ack_r;
    rdat_nxt  = rdat_r;
    // Events are or-ed in after the writes so a set beats a clear
    stat_nxt  = stat_r;
    earlyRdy_nxt = earlyRdy_r | earlyEvent;
    if (wrAcc && wb_sel_i == 4'hf) begin
      if (wb_adr_i[5:2] == `ADR_CTRL2) begin
        ctrl2_nxt = wb_dat_i & `CTRL2_MASK;
      end else if (wb_adr_i[5:2] == `ADR_TRGMODE) begin
        trg_nxt = wb_dat_i & `TRGMODE_MASK;
      end else if (wb_adr_i[5:2] == `ADR_EIEN) begin
        eien_nxt = wb_dat_i[7:0];
      end else if (wb_adr_i[5:2] == `ADR_GIEN) begin
        gien_nxt = wb_dat_i[7:0];
      end else if (wb_adr_i[5:2] == `ADR_STATUS) begin
        stat_nxt = stat_r & ~wb_dat_i[1:0];
      end else if (wb_adr_i[5:2] == `ADR_MASK) begin
        mask_nxt = wb_dat_i[1:0];
      end else if (wb_adr_i[5:2] == `ADR_EARLY_RDY) begin
        earlyRdy_nxt = (earlyRdy_r & ~wb_dat_i[7:0]) | earlyEvent;
      end
    end
    // Rising edges of the external flags become sticky events
    if (ctrl2_r[`BIT_REFIEN] && ref_fault_flag && !rfD_r) begin
      stat_nxt[0] = 1'b1;
    end
    if (ctrl2_r[`BIT_EOS_EN] && end_of_scan_ready_flag && !eosD_r) begin
      stat_nxt[1] = 1'b1;
    end
    if (rdAcc) begin
      if (wb_adr_i[5:2] == `ADR_CTRL2) begin
        rdat_nxt = ctrl2_r;
      end else if (wb_adr_i[5:2] == `ADR_TRGMODE) begin
        rdat_nxt = trg_r;
      end else if (wb_adr_i[5:2] == `ADR_EIEN) begin
        rdat_nxt = {24'h000000, eien_r};
      end else if (wb_adr_i[5:2] == `ADR_GIEN) begin
        rdat_nxt = {24'h000000, gien_r};
      end else if (wb_adr_i[5:2] == `ADR_STATUS) begin
        rdat_nxt = {30'h0, stat_r};
      end else if (wb_adr_i[5:2] == `ADR_MASK) begin
        rdat_nxt = {30'h0, mask_r};
      end else if (wb_adr_i[5:2] == `ADR_EARLY_RDY) begin
        rdat_nxt = {24'h000000, earlyRdy_r};
      end else begin
        rdat_nxt = 32'h00000000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl2_r <= `CTRL2_RESET;
      trg_r   <= 32'h00000000;
      eien_r  <= 8'h00;
      gien_r  <= 8'h00;
      earlyRdy_r <= 8'h00;
      stat_r  <= 2'h0;
      mask_r  <= 2'h0;
      ack_r   <= 1'b0;
      rdat_r  <= 32'h00000000;
      rfD_r   <= 1'b0;
      eosD_r  <= 1'b0;
    end else begin
      ctrl2_r <= ctrl2_nxt;
      trg_r   <= trg_nxt;
      eien_r  <= eien_nxt;
      gien_r  <= gien_nxt;
      earlyRdy_r <= earlyRdy_nxt;
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      ack_r   <= ack_nxt;
      rdat_r  <= rdat_nxt;
      rfD_r   <= ref_fault_flag;
      eosD_r  <= end_of_scan_ready_flag;
    end
  end

  // Registered ack costs a wait state but keeps decode off the bus path
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // Early gating by override selection
  assign gate = ctrl2_r[`BIT_EIOVR] ? eien_r : gien_r;
  assign earlyIrq = |(earlyRdy_r & gate);
  // Early flags have no mask bit; their enables gate them instead
  assign irq = |(stat_r & mask_r) | earlyIrq;

  // Shared core clock: toggle every n control clocks
  always_comb begin
    divCnt_nxt = divCnt_r;
    sclk_nxt   = sclk_r;
    // Zero is reserved; hold the clock still rather than run wild
    if (divVal == 7'h00) begin
      divCnt_nxt = 7'h00;
    end else if (divVal != divLast_r) begin
      divCnt_nxt = 7'h00;
    end else if (divCnt_r + 7'h01 >= divVal) begin
      divCnt_nxt = 7'h00;
      sclk_nxt   = ~sclk_r;
    end else begin
      divCnt_nxt = divCnt_r + 7'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      divCnt_r  <= 7'h00;
      divLast_r <= 7'h00;
      sclk_r    <= 1'b0;
    end else begin
      divCnt_r  <= divCnt_nxt;
      divLast_r <= divVal;
      sclk_r    <= sclk_nxt;
    end
  end

  assign shared_core_clock = sclk_r;
  assign sharedCoreTick = sclk_nxt & ~sclk_r;

  // Conversion countdown in shared-core clocks; lead set by software
  always_comb begin
    cst_nxt     = cst_r;
    convCnt_nxt = convCnt_r;
    dri_nxt     = 1'b0;
    case (cst_r)
      adc_ctrl_pkg::CONV_IDLE: begin
        if (convStart) begin
          cst_nxt     = adc_ctrl_pkg::CONV_RUN;
          convCnt_nxt = 5'(CONV_CLOCKS);
        end
      end
      adc_ctrl_pkg::CONV_RUN: begin
        if (sharedCoreTick) begin
          convCnt_nxt = convCnt_r - 5'h01;
          if (convCnt_r == {2'b00, ctrl2_r[10:8]} + 5'h01) begin
            dri_nxt = 1'b1;
          end
          if (convCnt_r == 5'h01) begin
            cst_nxt = adc_ctrl_pkg::CONV_IDLE;
          end
        end
      end
      default: cst_nxt = adc_ctrl_pkg::CONV_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cst_r     <= adc_ctrl_pkg::CONV_IDLE;
      convCnt_r <= 5'h00;
      dri_r     <= 1'b0;
    end else begin
      cst_r     <= cst_nxt;
      convCnt_r <= convCnt_nxt;
      dri_r     <= dri_nxt;
    end
  end

  assign dataReadyIrq = dri_r;

  // Per-core trigger path and first-sample sync
  genvar g;
  generate
    for (g = 0; g < `NUM_CORES; g++) begin : gCore
      // A change counts only once the two late stages agree
      assign agreed[g] = (s2_r[g] == s3_r[g]) ? s2_r[g] : trigD_r[g];
      if (g < 2) begin : gPre
        // Presync skips the chain; only safe for triggers on this clock
        assign trg_o_nxt[g] = trg_r[8+g] ? triggerIn[g] : agreed[g];
      end else begin : gSync
        assign trg_o_nxt[g] = agreed[g];
      end
      assign ss_nxt[g] = trg_r[g] & idleD_r[g] & trg_o_nxt[g];
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_r    <= 5'h00;
      s2_r    <= 5'h00;
      s3_r    <= 5'h00;
      trigD_r <= 5'h00;
      idleD_r <= 5'h1f;
      syncSampleNow <= 5'h00;
    end else begin
      s1_r    <= triggerIn;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      trigD_r <= trg_o_nxt;
      idleD_r <= coreIdle;
      syncSampleNow <= ss_nxt;
    end
  end

  assign coreTrigger = trigD_r;

  a_ref_irq_gate: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (!ctrl2_r[`BIT_REFIEN] && !stat_r[0]) |=> !stat_r[0])
    else $error("ref fault set while disabled");
  a_irq_level: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ((stat_r & mask_r) != 2'h0) |-> irq)
    else $error("unmasked status without irq");
  a_eos_irq_set: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (ctrl2_r[`BIT_EOS_EN] && end_of_scan_ready_flag && !eosD_r) |=> stat_r[1])
    else $error("eos flag not caught");
  a_early_gate_sel: assert property (@(posedge mclk)
    disable iff (!rst_n)
    earlyIrq == |(earlyRdy_r & (ctrl2_r[12] ? eien_r : gien_r)))
    else $error("early gate wrong");
  a_ready_lead: assert property (@(posedge mclk)
    disable iff (!rst_n)
    dataReadyIrq |-> convCnt_r == {2'b00, ctrl2_r[10:8]})
    else $error("ready lead wrong");
  a_div_half: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (divVal == 7'h02 && $stable(divVal) && $changed(sclk_r))
      |=> divVal != 7'h02 or (!$changed(sclk_r) ##1 $changed(sclk_r)))
    else $error("divide by two period wrong");
  a_div_reload: assert property (@(posedge mclk)
    disable iff (!rst_n)
    $changed(divVal) |=> $stable(sclk_r))
    else $error("divider change did not restart");
  a_presync_path: assert property (@(posedge mclk)
    disable iff (!rst_n)
    trg_r[8] |=> coreTrigger[0] == $past(triggerIn[0]))
    else $error("presync path wrong");
  a_sync_core0: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (!$past(trg_r[8]) && $rose(coreTrigger[0]))
      |-> $past(triggerIn[0], 3) && $past(triggerIn[0], 4))
    else $error("core 0 chain bypassed");
  a_sync_sample: assert property (@(posedge mclk)
    disable iff (!rst_n)
    !trg_r[2] |=> !syncSampleNow[2])
    else $error("sync sample while disabled");
  a_zero_bits: assert property (@(posedge mclk)
    disable iff (!rst_n)
    ctrl2_r[11] == 1'b0 && ctrl2_r[7] == 1'b0 && trg_r[7:5] == 3'h0)
    else $error("unused bits set");
  a_early_flag: assert property (@(posedge mclk)
    disable iff (!rst_n)
    earlyEvent[0] |=> earlyRdy_r[0])
    else $error("early flag lost");
  a_sync_chain: assert property (@(posedge mclk)
    disable iff (!rst_n)
    $rose(coreTrigger[2]) |-> $past(triggerIn[2], 3) && $past(triggerIn[2], 4))
    else $error("sync chain bypassed");
endmodule // adc_ctrl
`default_nettype wire

// ==== bench/adc_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module adc_core_model (
  input  wire logic       mclk,
  input  wire logic [4:0] fire,
  input  wire logic [4:0] idle,
  output logic      [4:0] triggerIn,
  output logic      [4:0] coreIdle
);
  logic [2:0] hold  = 3'h0;
  logic [4:0] trigQ = 5'h00;
  // Held seven clocks so even the slow path must catch it
  always @(posedge mclk) begin
    if (fire != 5'h00) begin
      trigQ <= fire;
      hold <= 3'h6;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end else begin
      trigQ <= 5'h00;
    end
  end
  assign triggerIn = trigQ;
  assign coreIdle = idle;
endmodule // adc_core_model
`default_nettype wire

// ==== bench/adc_ctrl_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_tb_top;
  logic        mclk, rst_n, cyc, stb, we, convStart, ack;
  logic        scc, tick, dri, eirq, irq, seen;
  logic [5:0]  adr;
  logic [31:0] wdat, rdat, dout;
  logic [1:0]  flg;
  logic [7:0]  early;
  logic [4:0]  trg, idle, fire, ctrg, ssn, coreIdle;
  logic [6:0]  dv [4] = '{7'h1, 7'h2, 7'h3, 7'h7f};
  int          fails, checked, n, lp, ln;
  adc_ctrl #(.CONV_CLOCKS(14)) uut (.mclk(mclk), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .ref_fault_flag(flg[0]), .end_of_scan_ready_flag(flg[1]),
    .convStart(convStart), .earlyEvent(early), .triggerIn(trg),
    .coreIdle(coreIdle), .shared_core_clock(scc),
    .sharedCoreTick(tick), .dataReadyIrq(dri), .earlyIrq(eirq),
    .coreTrigger(ctrg), .syncSampleNow(ssn), .irq(irq));
  adc_core_model core (.mclk(mclk), .fire(fire), .idle(idle),
    .triggerIn(trg), .coreIdle(coreIdle));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic wrap_up();
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    step(1);
    while (ack !== 1'b1 && k < 50) begin
      step(1);
      k++;
    end
    chk(k < 50, 1);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // Counts clocks up to the next low-to-high of the shared clock
  task automatic rise();
    logic p;
    p = 1'b1;
    while (!(p === 1'b0 && scc === 1'b1) && n < 999) begin
      p = scc;
      step(1);
      n++;
    end
  endtask
  task automatic conv(output int c);
    int k;
    c = 0;
    k = 0;
    convStart <= 1'b1;
    step(1);
    convStart <= 1'b0;
    while (dri !== 1'b1 && k < 300) begin
      step(1);
      k++;
      c = c + (tick === 1'b1);
    end
    chk(k < 300, 1);
    step(40);
  endtask
  task automatic trig(input int c, output int lat, output logic s);
    lat = 99;
    s = 1'b0;
    fire <= 5'h1 << c;
    step(1);
    fire <= 5'h0;
    for (int i = 0; i < 20; i++) begin
      step(1);
      if (ctrg[c] === 1'b1 && lat == 99) lat = i;
      s = s | (ssn[c] === 1'b1);
    end
  endtask
  initial begin
    {rst_n, cyc, stb, we, convStart} = 5'h0;
    {adr, wdat, flg, early, fire, idle} = '0;
    step(8);
    rst_n <= 1'b1;
    step(1);
    rd(6'h00, 32'h1);
    rd(6'h04, 32'h0);
    rd(6'h3c, 32'h0);
    wb(1'b1, 6'h00, 32'hffff_ffff);
    rd(6'h00, 32'h777f);
    wb(1'b1, 6'h04, 32'hffff_ffff);
    rd(6'h04, 32'h31f);
    foreach (dv[i]) begin
      wb(1'b1, 6'h00, {25'h0, dv[i]});
      n = 0;
      rise();
      rise();
      n = 0;
      rise();
      chk(n, 2 * dv[i]);
    end
    wb(1'b1, 6'h14, 32'h3);
    for (int i = 0; i < 2; i++) begin
      for (int e = 0; e < 2; e++) begin
        wb(1'b1, 6'h00, 32'h1 | (e << (14 - i)));
        flg[i] <= 1'b1;
        step(4);
        chk(irq, e);
        rd(6'h10, e << i);
        wb(1'b1, 6'h14, 32'h0);
        step(2);
        chk(irq, 0);
        wb(1'b1, 6'h14, 32'h3);
        flg[i] <= 1'b0;
        wb(1'b1, 6'h10, 32'h3);
        step(2);
        rd(6'h10, 0);
        chk(irq, 0);
      end
    end
    wb(1'b1, 6'h08, 32'h1);
    wb(1'b1, 6'h0c, 32'h2);
    for (int o = 0; o < 2; o++) begin
      wb(1'b1, 6'h00, 32'h1 | (o << 12));
      for (int b = 0; b < 2; b++) begin
        early <= 8'h1 << b;
        step(1);
        early <= 8'h0;
        step(3);
        chk(eirq, o ^ b);
        chk(irq, o ^ b);
        wb(1'b1, 6'h18, 32'hff);
        step(2);
        chk(eirq, 0);
      end
    end
    // Twelve-bit results assumed, so every lead code is legal
    for (int l = 0; l < 8; l++) begin
      wb(1'b1, 6'h00, 32'h1 | (l << 8));
      conv(n);
      chk(n, 14 - l);
    end
    idle <= 5'h1f;
    for (int c = 0; c < 2; c++) begin
      wb(1'b1, 6'h04, 32'h100 << c);
      trig(c, lp, seen);
      wb(1'b1, 6'h04, 32'h0);
      trig(c, ln, seen);
      chk(ln - lp >= 2 && ln < 99, 1);
    end
    for (int c = 0; c < 5; c++) begin
      for (int e = 0; e < 2; e++) begin
        wb(1'b1, 6'h04, e << c);
        trig(c, n, seen);
        chk(seen, e);
        chk(n < 99, 1);
      end
    end
    wb(1'b1, 6'h04, 32'h10);
    idle <= 5'h00;
    trig(4, n, seen);
    chk(seen, 0);
    wrap_up();
  end
  initial begin
    step(30000);
    fails++;
    wrap_up();
  end
endmodule // adc_ctrl_tb_top
`default_nettype wire
